// ===== pkg/sram_host_pkg.sv
// constants and types for the async sram host controller
package sram_host_pkg;
	localparam int ADDR_W = 15;
	localparam int DATA_W = 16;
	localparam int CLK_PERIOD_NS = 40;
	// device timing, ns
	localparam int READ_PERIOD_MIN_NS = 15;
	localparam int ADDRESS_ACCESS_TIME_NS = 15;
	localparam int OUTPUT_HOLD_AFTER_ADDR_NS = 3;
	localparam int CE_ACCESS_NS = 15;
	localparam int OE_ACCESS_NS = 7;
	localparam int LANE_ACCESS_NS = 7;
	localparam int LANE_FLOAT_NS = 7;
	localparam int WRITE_PERIOD_MIN_NS = 15;
	localparam int CE_TO_END_NS = 10;
	localparam int ADDR_TO_END_NS = 10;
	localparam int WRITE_PULSE_MIN_NS = 10;
	localparam int DIN_SETUP_BEFORE_END_NS = 8;
	localparam int STROBE_TO_FLOAT_DELAY_NS = 4;
	localparam int LANE_ENABLE_TO_END_NS = 10;
	// derived cycle counts (minimums round up)
	localparam int READ_ACCESS_NS = ADDRESS_ACCESS_TIME_NS;
	localparam int READ_WAIT_CYC = (READ_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int WR_PULSE_NS = STROBE_TO_FLOAT_DELAY_NS + DIN_SETUP_BEFORE_END_NS;
	localparam int WRITE_PULSE_CYC = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FLOAT_CYC = (LANE_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 3;
	localparam logic [CNT_W-1:0] READ_WAIT = CNT_W'(READ_WAIT_CYC);
	localparam logic [CNT_W-1:0] WRITE_PULSE = CNT_W'(WRITE_PULSE_CYC);
	localparam logic [CNT_W-1:0] FLOAT_WAIT = CNT_W'(FLOAT_CYC);
	localparam logic [CNT_W-1:0] CNT_ZERO = 3'h0;
	localparam logic [CNT_W-1:0] CNT_ONE = 3'h1;
	typedef enum logic [2:0]
	{
		ST_IDLE = 3'h0,
		ST_RD_WAIT = 3'h1,
		ST_RD_DONE = 3'h3,
		ST_WR_PULSE = 3'h4,
		ST_WR_END = 3'h6,
		ST_RECOVER = 3'h2
	} host_state_e;
endpackage

// ===== pkg/sram_pin_if.sv
// interface carrying sram pin drives between controller and pin stage
`timescale 1ns/100ps
interface sram_pin_if;
	import sram_host_pkg::*;
	logic chip_sel_n;
	logic write_n;
	logic out_en_n;
	logic low_lane_enable_n;
	logic high_lane_enable_n;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic drive;
	logic [DATA_W-1:0] rdata;
	modport ctrl (output chip_sel_n, write_n, out_en_n, low_lane_enable_n,
		high_lane_enable_n, addr, wdata, drive, input rdata);
	modport pins (input chip_sel_n, write_n, out_en_n, low_lane_enable_n,
		high_lane_enable_n, addr, wdata, drive, output rdata);
endinterface

// ===== rtl/sram_pin_stage.sv
// pin stage: strobes passed straight through from the controller registers, two-flop synchronised read data in
`timescale 1ns/100ps
module sram_pin_stage
	import sram_host_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	sram_pin_if.pins p,
	output logic sram_ce_n,
	output logic sram_we_n,
	output logic sram_oe_n,
	output logic sram_lb_n,
	output logic sram_ub_n,
	output logic [ADDR_W-1:0] sram_addr,
	output logic [DATA_W-1:0] sram_dq_out,
	output logic [DATA_W-1:0] sram_dq_oe,
	input wire logic [DATA_W-1:0] sram_dq_in
);
	logic [DATA_W-1:0] dq_meta;
	logic [DATA_W-1:0] dq_sync;
	assign p.rdata = dq_sync;
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			dq_meta <= 16'h0000;
			dq_sync <= 16'h0000;
		end
		else if (clk_en)
		begin
			dq_meta <= sram_dq_in;
			dq_sync <= dq_meta;
		end
	end
	assign sram_ce_n = p.chip_sel_n;
	assign sram_we_n = p.write_n;
	assign sram_oe_n = p.out_en_n;
	assign sram_lb_n = p.low_lane_enable_n;
	assign sram_ub_n = p.high_lane_enable_n;
	assign sram_addr = p.addr;
	assign sram_dq_out = p.wdata;
	// per lane bit output enable follows the lane enable during write drive
	genvar i;
	generate
		for (i = 0; i < DATA_W; i++)
		begin : g_oe
			if (i < 8)
			begin : g_lo
				assign sram_dq_oe[i] = p.drive & ~p.low_lane_enable_n;
			end
			else
			begin : g_hi
				assign sram_dq_oe[i] = p.drive & ~p.high_lane_enable_n;
			end
		end
	endgenerate
endmodule

// ===== rtl/sram_host_ctrl.sv
// host controller issuing single reads and writes to an async sram
`timescale 1ns/100ps
// Summary of operation
// - address and select held 10 ns before write end; strobe low 10 ns
// - address may change right at write start and write end
// - write data stable 8 ns before write end; may drop at end
// - lane enables low 10 ns before write end; writes spaced 15 ns
// - write happens only with select, strobe and a lane enable low
// - first of these signals to rise ends the write
// - strobe pulse at least 4 ns float plus 8 ns setup
// - read needs strobe high; device drives only with select and oe low
// - address valid before or with select falling in reads
// - host never drives data pins while device drives them
module sram_host_ctrl
	import sram_host_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_write,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [DATA_W-1:0] req_wdata,
	input wire logic [1:0] req_lanes,
	output logic rsp_valid,
	output logic [DATA_W-1:0] rsp_rdata,
	output logic sram_ce_n,
	output logic sram_we_n,
	output logic sram_oe_n,
	output logic sram_lb_n,
	output logic sram_ub_n,
	output logic [ADDR_W-1:0] sram_addr,
	output logic [DATA_W-1:0] sram_dq_out,
	output logic [DATA_W-1:0] sram_dq_oe,
	input wire logic [DATA_W-1:0] sram_dq_in
);
	sram_pin_if pif ();
	host_state_e state;
	host_state_e next_state;
	logic [CNT_W-1:0] cnt;
	logic [CNT_W-1:0] next_cnt;
	logic ce_n;
	logic we_n;
	logic oe_n;
	logic lb_n;
	logic ub_n;
	logic drive;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [1:0] lanes;
	logic rsp_pend;
	logic [DATA_W-1:0] rdata_mask;
	logic no_lane;
	logic next_sel;
	logic next_rd;
	logic next_wr;
	logic next_lane_on;
	logic [1:0] lane_src;
	wire logic take = req_valid & req_ready;
	wire logic cnt_done = (cnt == CNT_ZERO);
	// a request with no lane selected would never form a write overlap
	assign no_lane = (req_lanes == 2'b00);
	assign req_ready = (state == ST_IDLE);
	assign rdata_mask = {{8{lanes[1]}}, {8{lanes[0]}}};
	// select falls on the same edge that registers the address
	assign next_sel = (next_state inside {ST_RD_WAIT, ST_RD_DONE, ST_WR_PULSE});
	assign next_rd = (next_state inside {ST_RD_WAIT, ST_RD_DONE});
	assign next_wr = (next_state inside {ST_WR_PULSE, ST_WR_END});
	assign next_lane_on = next_rd | next_wr;
	assign lane_src = (state == ST_IDLE) ? req_lanes : lanes;
	always_comb
	begin
		next_state = state;
		next_cnt = cnt;
		case (state)
			ST_IDLE:
			begin
				if (take && !no_lane)
				begin
					next_state = req_write ? ST_WR_PULSE : ST_RD_WAIT;
					next_cnt = req_write ? WRITE_PULSE : READ_WAIT;
				end
			end
			ST_RD_WAIT:
			begin
				next_cnt = cnt - CNT_ONE;
				if (cnt == CNT_ONE)
					next_state = ST_RD_DONE;
			end
			ST_RD_DONE:
			begin
				// two flop sync delay: sample once synchronised data settled
				next_cnt = cnt - CNT_ONE;
				if (cnt_done)
				begin
					next_state = ST_RECOVER;
					next_cnt = FLOAT_WAIT;
				end
			end
			ST_WR_PULSE:
			begin
				next_cnt = cnt - CNT_ONE;
				if (cnt == CNT_ONE)
					next_state = ST_WR_END;
			end
			ST_WR_END:
			begin
				next_state = ST_RECOVER;
				next_cnt = FLOAT_WAIT;
			end
			ST_RECOVER:
			begin
				next_cnt = cnt - CNT_ONE;
				if (cnt_done || cnt == CNT_ONE)
					next_state = ST_IDLE;
			end
			default:
			begin
				next_state = ST_IDLE;
				next_cnt = CNT_ZERO;
			end
		endcase
	end
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			state <= ST_IDLE;
			cnt <= CNT_ZERO;
		end
		else if (clk_en)
		begin
			state <= next_state;
			cnt <= next_cnt;
		end
	end
	// request capture; address and data held for the whole access
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			addr <= 15'h0000;
			wdata <= 16'h0000;
			lanes <= 2'h0;
		end
		else if (clk_en && take && !no_lane)
		begin
			addr <= req_addr;
			wdata <= req_wdata;
			lanes <= req_lanes;
		end
	end
	// pin drive: select, lanes and address set with the strobe, all held to the end
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			ce_n <= 1'b1;
			we_n <= 1'b1;
			oe_n <= 1'b1;
			lb_n <= 1'b1;
			ub_n <= 1'b1;
			drive <= 1'b0;
		end
		else if (clk_en)
		begin
			ce_n <= !next_sel;
			// strobe and select rise together to end the write; lanes and data drive release a cycle later
			we_n <= (next_state != ST_WR_PULSE);
			oe_n <= !next_rd;
			lb_n <= !(next_lane_on && lane_src[0]);
			ub_n <= !(next_lane_on && lane_src[1]);
			drive <= next_wr;
		end
	end
	// read response from synchronised data, disabled lanes zero
	always_ff @(posedge core_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rsp_valid <= 1'b0;
			rsp_rdata <= 16'h0000;
			rsp_pend <= 1'b0;
		end
		else if (clk_en)
		begin
			rsp_pend <= (state == ST_RD_DONE) && cnt_done;
			rsp_valid <= rsp_pend;
			if (rsp_pend)
				rsp_rdata <= pif.rdata & rdata_mask;
		end
	end
	assign pif.chip_sel_n = ce_n;
	assign pif.write_n = we_n;
	assign pif.out_en_n = oe_n;
	assign pif.low_lane_enable_n = lb_n;
	assign pif.high_lane_enable_n = ub_n;
	assign pif.addr = addr;
	assign pif.wdata = wdata;
	assign pif.drive = drive & oe_n;
	sram_pin_stage u_pins
	(
		.core_clk(core_clk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.p(pif.pins),
		.sram_ce_n(sram_ce_n),
		.sram_we_n(sram_we_n),
		.sram_oe_n(sram_oe_n),
		.sram_lb_n(sram_lb_n),
		.sram_ub_n(sram_ub_n),
		.sram_addr(sram_addr),
		.sram_dq_out(sram_dq_out),
		.sram_dq_oe(sram_dq_oe),
		.sram_dq_in(sram_dq_in)
	);
endmodule

// ===== tb/sram_host_ctrl_asserts.sv
// pin timing checker for the sram host controller
`timescale 1ns/100ps
module sram_host_ctrl_asserts
	import sram_host_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic clk_en,
	input wire logic req_ready,
	input wire logic rsp_valid,
	input wire logic sram_ce_n,
	input wire logic sram_we_n,
	input wire logic sram_oe_n,
	input wire logic sram_lb_n,
	input wire logic sram_ub_n,
	input wire logic [ADDR_W-1:0] sram_addr,
	input wire logic [DATA_W-1:0] sram_dq_out,
	input wire logic [DATA_W-1:0] sram_dq_oe
);
	logic en_q = 1'b0;
	logic gclk;
	// enable moves only at rising edges, so a falling edge copy gates without glitches
	always @(negedge core_clk)
		en_q <= clk_en;
	assign gclk = core_clk & en_q;
	default clocking @(posedge gclk); endclocking
	default disable iff (!rst_b);
	property p_rd_we; !sram_oe_n |-> sram_we_n; endproperty
	a_rd_we: assert property (p_rd_we) else $error("oe low with we low");
	property p_no_clash; !sram_oe_n |-> sram_dq_oe == '0; endproperty
	a_no_clash: assert property (p_no_clash) else $error("drive during read");
	property p_wr_all; !sram_we_n |-> !sram_ce_n && !(sram_lb_n && sram_ub_n); endproperty
	a_wr_all: assert property (p_wr_all) else $error("write without overlap");
	property p_wr_pulse; $fell(sram_we_n) |=> sram_we_n && sram_ce_n; endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("write pulse length");
	property p_wr_end;
		$rose(sram_we_n) |-> $stable(sram_addr) && $stable(sram_dq_out) && sram_dq_oe != '0;
	endproperty
	a_wr_end: assert property (p_wr_end) else $error("data or address moved at end");
	property p_lane_oe;
		!sram_we_n |-> sram_dq_oe == {{8{!sram_ub_n}}, {8{!sram_lb_n}}};
	endproperty
	a_lane_oe: assert property (p_lane_oe) else $error("lane drive mismatch");
	property p_rd_len; $fell(sram_oe_n) |=> !sram_oe_n ##1 sram_oe_n; endproperty
	a_rd_len: assert property (p_rd_len) else $error("read window length");
	property p_rsp; $fell(sram_oe_n) |-> ##3 rsp_valid; endproperty
	a_rsp: assert property (p_rsp) else $error("read answer late");
	property p_addr; !sram_ce_n && !$past(sram_ce_n) |-> $stable(sram_addr); endproperty
	a_addr: assert property (p_addr) else $error("address moved while selected");
	property p_busy; !sram_ce_n |-> !req_ready; endproperty
	a_busy: assert property (p_busy) else $error("ready during access");
	c_rd: cover property (rsp_valid);
	c_wr_low: cover property (!sram_we_n && sram_ub_n);
	c_wr_high: cover property (!sram_we_n && sram_lb_n);
endmodule
bind sram_host_ctrl sram_host_ctrl_asserts u_chk (.*);

// ===== tb/sram_dev.sv
// behavioural async sram on the far side of the controller
`timescale 1ns/100ps
module sram_dev #(parameter int DLY = 5)
(
	input wire logic sram_ce_n,
	input wire logic sram_we_n,
	input wire logic sram_oe_n,
	input wire logic sram_lb_n,
	input wire logic sram_ub_n,
	input wire logic [14:0] sram_addr,
	input wire logic [15:0] sram_dq_out,
	input wire logic [15:0] sram_dq_oe,
	output logic [15:0] sram_dq_in
);
	logic [15:0] mem [0:32767];
	logic [15:0] flt = 16'h5A3C;
	logic [15:0] lvl;
	logic [15:0] den;
	logic rd;
	logic wr_on;
	logic [14:0] wr_addr;
	logic [15:0] wr_data;
	logic [1:0] wr_lane;
	always #40 flt = ~flt;
	assign rd = !sram_ce_n && !sram_oe_n && sram_we_n;
	assign den = {{8{rd && !sram_ub_n}}, {8{rd && !sram_lb_n}}};
	always @*
		for (int i = 0; i < 16; i++)
			lvl[i] = sram_dq_oe[i] ? sram_dq_out[i] : den[i] ? mem[sram_addr][i] : flt[i];
	assign wr_on = !sram_ce_n && !sram_we_n && !(sram_lb_n && sram_ub_n);
	// track the overlap and store when it ends, so skew at the start hits no wrong word
	always_latch
		if (wr_on)
		begin
			wr_addr = sram_addr;
			wr_data = lvl;
			wr_lane = {!sram_ub_n, !sram_lb_n};
		end
	always @(negedge wr_on)
	begin
		if (wr_lane[0])
			mem[wr_addr][7:0] = wr_data[7:0];
		if (wr_lane[1])
			mem[wr_addr][15:8] = wr_data[15:8];
	end
	assign #(DLY) sram_dq_in = lvl;
endmodule

// ===== tb/tb_sram_host_ctrl.sv
// self-checking bench for the sram host controller
`timescale 1ns/100ps
module tb_sram_host_ctrl;
	import sram_host_pkg::*;
	logic core_clk = 0;
	logic rst_b = 0;
	logic req_valid = 0;
	logic req_write = 0;
	logic [ADDR_W-1:0] req_addr = '0;
	logic [DATA_W-1:0] req_wdata = '0;
	logic [1:0] req_lanes = '0;
	logic clk_en = 1'b1;
	logic stall_on = 1'b0;
	logic [15:0] en_lfsr = 16'h0009;
	logic req_ready, rsp_valid, sram_ce_n, sram_we_n, sram_oe_n, sram_lb_n, sram_ub_n;
	logic [ADDR_W-1:0] sram_addr;
	logic [DATA_W-1:0] rsp_rdata, sram_dq_out, sram_dq_oe, sram_dq_in;
	int fail_count = 0;
	int n_checks = 0;
	int cyc = 0;
	logic [15:0] lfsr = 16'h0009;
	logic [15:0] ref_mem [int];
	always #20 core_clk = ~core_clk;
	sram_host_ctrl u_dut (.*);
	sram_dev #(.DLY(12)) u_mem (.*);
	function automatic logic [15:0] nxt(logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	function automatic logic [14:0] adr(int i);
		return (i == 7) ? 15'h7FFF : 15'(i);
	endfunction
	// random freeze cycles while stalling is on
	always @(posedge core_clk)
	begin
		en_lfsr <= nxt(en_lfsr);
		clk_en <= !stall_on || (en_lfsr[1:0] != 2'b00);
	end
	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		n_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d errors %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic issue(logic w, logic [14:0] a, logic [15:0] d, logic [1:0] ln);
		req_valid <= 1'b1;
		req_write <= w;
		req_addr <= a;
		req_wdata <= d;
		req_lanes <= ln;
		do @(negedge core_clk); while (!(req_ready === 1'b1 && clk_en === 1'b1));
		@(posedge core_clk);
	endtask
	task automatic wr(logic [14:0] a, logic [15:0] d, logic [1:0] ln);
		issue(1'b1, a, d, ln);
		if (ln[0]) ref_mem[a][7:0] = d[7:0];
		if (ln[1]) ref_mem[a][15:8] = d[15:8];
	endtask
	task automatic rd(logic [14:0] a, logic [1:0] ln);
		logic [15:0] e;
		bit seen;
		seen = 0;
		e = ref_mem[a] & {{8{ln[1]}}, {8{ln[0]}}};
		issue(1'b0, a, 16'h0000, ln);
		req_valid <= 1'b0;
		for (int k = 0; k < 32 && !seen; k++)
		begin
			@(negedge core_clk);
			if (rsp_valid === 1'b1)
			begin
				seen = 1;
				chk("rsp_rdata", e, rsp_rdata);
			end
		end
		chk("rsp_seen", {15'h0, ln != 2'b00}, {15'h0, seen});
		@(posedge core_clk);
	endtask
	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fail_count++;
			print_verdict();
		end
	end
	initial
	begin
		repeat (20) @(posedge core_clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 8; i++)
		begin
			lfsr = nxt(lfsr);
			wr(adr(i), lfsr, 2'h3);
		end
		stall_on <= 1'b1;
		for (int i = 0; i < 60; i++)
		begin
			lfsr = nxt(lfsr);
			if (lfsr[0])
				wr(adr(lfsr[3:1]), nxt(lfsr), lfsr[5:4]);
			else
				rd(adr(lfsr[3:1]), lfsr[5:4]);
		end
		req_valid <= 1'b0;
		stall_on <= 1'b0;
		// let any access finish so reset cuts no write pulse
		repeat (6) @(posedge core_clk);
		rst_b <= 1'b0;
		repeat (3) @(posedge core_clk);
		rst_b <= 1'b1;
		for (int i = 0; i < 8; i++)
			rd(adr(i), 2'h3);
		print_verdict();
	end
endmodule
